// File: rtm_defs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the top-level monitor module only.
`ifndef RTM_DEFS_SVH
`define RTM_DEFS_SVH
`define RTM_STATUS_OFFSET 8'h90
`define RTM_IRQ_STATUS_OFFSET 8'hA0
`define RTM_IRQ_ENABLE_OFFSET 8'hA4
`define RTM_IRQ_CLEAR_OFFSET 8'hA8
`define RTM_HOST_EN_BIT 7
`define RTM_CARD_EN_BIT 6
`define RTM_CARD_FLAG_BIT 3
`define RTM_HOST_FLAG_BIT 1
`define RTM_STATUS_RESET 8'hC0
`define RTM_STATUS_WMASK 8'hC0
`define RTM_TIMEOUT_CYCLES 32768
`define RTM_IRQ_HOST_BIT 0
`define RTM_IRQ_CARD_BIT 1
`endif

// File: rtm_pkg.sv
// Types shared by the retry timeout monitor modules.
// Assumes rtm_defs.svh is on the include path.
package rtm_pkg;
	typedef enum logic [1:0] {
		RTM_BUS_IDLE,
		RTM_BUS_WRESP,
		RTM_BUS_RDATA
	} rtm_bus_state_e;
	typedef logic [7:0] rtm_byte_t;
endpackage

// File: rtm_side_timer.sv
// One side's retry timeout counter.
// Assumes retry and reissue strobes synchronous to aclk.
`timescale 1ns/1ps
module rtm_side_timer #(
	parameter int LIMIT = 32768
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic retry_issued,
	input wire logic request_reissued,
	output logic expired
);
	localparam int W = $clog2(LIMIT) + 1;
	logic [W-1:0] count_reg;
	logic armed_reg;
	logic expired_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_reg <= 1'b0;
			count_reg <= '0;
		end else if (request_reissued || !enable) begin
			armed_reg <= 1'b0;
			count_reg <= '0;
		end else if (retry_issued) begin
			armed_reg <= 1'b1;
			count_reg <= '0;
		end else if (armed_reg) begin
			if (count_reg == W'(LIMIT - 1)) begin
				armed_reg <= 1'b0;
			end
			count_reg <= count_reg + 1'b1;
		end
	end
	// One-cycle pulse when the master stayed away for LIMIT cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			expired_reg <= 1'b0;
		end else begin
			expired_reg <= armed_reg && enable && !request_reissued &&
				!retry_issued && count_reg == W'(LIMIT - 1);
		end
	end
	assign expired = expired_reg;
endmodule

// File: rtm_irq_ctrl.sv
// Sticky interrupt status, enable mask and level output.
// Assumes event pulses and write strobes synchronous to aclk.
`timescale 1ns/1ps
module rtm_irq_ctrl #(
	parameter int N = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [N-1:0] events,
	input wire logic enable_we,
	input wire logic clear_we,
	input wire logic [N-1:0] wdata,
	output logic [N-1:0] status,
	output logic [N-1:0] enable,
	output logic irq
);
	logic [N-1:0] status_reg;
	logic [N-1:0] enable_reg;
	logic irq_reg;
	// Set wins over a clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~(clear_we ? wdata : '0)) | events;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_reg <= '0;
		end else if (enable_we) begin
			enable_reg <= wdata;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_reg & enable_reg);
		end
	end
	assign status = status_reg;
	assign enable = enable_reg;
	assign irq = irq_reg;
endmodule

// File: rtm_retry_timeout_monitor.sv
// Retry timeout monitor with an AXI4-Lite register slave.
// Assumes retry and reissue strobes from the bridge logic, all on aclk.
`timescale 1ns/1ps
`include "rtm_defs.svh"
module rtm_retry_timeout_monitor #(
	parameter int TIMEOUT_CYCLES = `RTM_TIMEOUT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic host_retry_issued,
	input wire logic host_request_reissued,
	input wire logic card_retry_issued,
	input wire logic card_request_reissued,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	output logic host_side_timeout_flag,
	output logic card_side_timeout_flag,
	output logic irq
);
	// Unmapped offsets are answered with a slave error and change nothing.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	rtm_pkg::rtm_bus_state_e wstate_reg;
	rtm_pkg::rtm_bus_state_e rstate_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;

	rtm_pkg::rtm_byte_t status_reg;
	logic host_flag_reg;
	logic card_flag_reg;
	logic host_expired;
	logic card_expired;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic irq_out;

	logic aw_take;
	logic w_take;
	logic wr_go;
	logic wr_lane0;
	logic wr_status;
	logic wr_irq_en;
	logic wr_irq_clr;
	logic wr_hit;
	rtm_pkg::rtm_byte_t status_view;

	assign aw_take = s_axil_awvalid && awready_reg;
	assign w_take = s_axil_wvalid && wready_reg;
	// A write commits once both halves are held and no response is pending.
	assign wr_go = wstate_reg == rtm_pkg::RTM_BUS_IDLE &&
		aw_held_reg && w_held_reg;
	assign wr_lane0 = wstrb_reg[0];
	assign wr_status = wr_go && awaddr_reg == `RTM_STATUS_OFFSET && wr_lane0;
	assign wr_irq_en = wr_go && awaddr_reg == `RTM_IRQ_ENABLE_OFFSET &&
		wr_lane0;
	assign wr_irq_clr = wr_go && awaddr_reg == `RTM_IRQ_CLEAR_OFFSET &&
		wr_lane0;
	assign wr_hit = awaddr_reg == `RTM_STATUS_OFFSET ||
		awaddr_reg == `RTM_IRQ_ENABLE_OFFSET ||
		awaddr_reg == `RTM_IRQ_CLEAR_OFFSET;

	// Write address and data are captured independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			awready_reg <= 1'b0;
		end else if (aw_take) begin
			aw_held_reg <= 1'b1;
			awaddr_reg <= {s_axil_awaddr[7:2], 2'b00};
			awready_reg <= 1'b0;
		end else if (wr_go) begin
			aw_held_reg <= 1'b0;
			awready_reg <= 1'b0;
		end else begin
			awready_reg <= !aw_held_reg &&
				wstate_reg == rtm_pkg::RTM_BUS_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			wready_reg <= 1'b0;
		end else if (w_take) begin
			w_held_reg <= 1'b1;
			wdata_reg <= s_axil_wdata;
			wstrb_reg <= s_axil_wstrb;
			wready_reg <= 1'b0;
		end else if (wr_go) begin
			w_held_reg <= 1'b0;
			wready_reg <= 1'b0;
		end else begin
			wready_reg <= !w_held_reg &&
				wstate_reg == rtm_pkg::RTM_BUS_IDLE;
		end
	end

	// The write response stands until the master accepts it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_reg <= rtm_pkg::RTM_BUS_IDLE;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			case (wstate_reg)
			rtm_pkg::RTM_BUS_IDLE: begin
				if (wr_go) begin
					wstate_reg <= rtm_pkg::RTM_BUS_WRESP;
					bvalid_reg <= 1'b1;
					bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				end
			end
			rtm_pkg::RTM_BUS_WRESP: begin
				if (s_axil_bready) begin
					wstate_reg <= rtm_pkg::RTM_BUS_IDLE;
					bvalid_reg <= 1'b0;
				end
			end
			default: begin
				wstate_reg <= rtm_pkg::RTM_BUS_IDLE;
				bvalid_reg <= 1'b0;
			end
			endcase
		end
	end

	// Only the enable bits hold written values; reserved bits stay zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= `RTM_STATUS_RESET;
		end else if (wr_status) begin
			status_reg <= wdata_reg[7:0] & `RTM_STATUS_WMASK;
		end
	end

	// Expiry sets win over a write-one clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_flag_reg <= 1'b0;
		end else if (host_expired) begin
			host_flag_reg <= 1'b1;
		end else if (wr_status && wdata_reg[`RTM_HOST_FLAG_BIT]) begin
			host_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			card_flag_reg <= 1'b0;
		end else if (card_expired) begin
			card_flag_reg <= 1'b1;
		end else if (wr_status && wdata_reg[`RTM_CARD_FLAG_BIT]) begin
			card_flag_reg <= 1'b0;
		end
	end

	// Each side counts only while its enable bit is set; clearing the bit
	// aborts a pending count but leaves an existing flag alone.
	rtm_side_timer #(
		.LIMIT(TIMEOUT_CYCLES)
	) u_host_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(status_reg[`RTM_HOST_EN_BIT]),
		.retry_issued(host_retry_issued),
		.request_reissued(host_request_reissued),
		.expired(host_expired)
	);

	rtm_side_timer #(
		.LIMIT(TIMEOUT_CYCLES)
	) u_card_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(status_reg[`RTM_CARD_EN_BIT]),
		.retry_issued(card_retry_issued),
		.request_reissued(card_request_reissued),
		.expired(card_expired)
	);

	// Expiry pulses also feed a separate interrupt status, so clearing a
	// flag bit does not clear the interrupt.
	rtm_irq_ctrl #(
		.N(2)
	) u_irq (
		.aclk(aclk),
		.aresetn(aresetn),
		.events({card_expired, host_expired}),
		.enable_we(wr_irq_en),
		.clear_we(wr_irq_clr),
		.wdata(wdata_reg[1:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq_out)
	);

	// The flag bits are merged over the enable bits for reads.
	always_comb begin
		status_view = status_reg;
		status_view[`RTM_HOST_FLAG_BIT] = host_flag_reg;
		status_view[`RTM_CARD_FLAG_BIT] = card_flag_reg;
	end

	// Read data is captured at the edge that takes the address and held
	// until the master raises rready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rstate_reg <= rtm_pkg::RTM_BUS_IDLE;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			case (rstate_reg)
			rtm_pkg::RTM_BUS_IDLE: begin
				arready_reg <= 1'b1;
				if (s_axil_arvalid && arready_reg) begin
					arready_reg <= 1'b0;
					rvalid_reg <= 1'b1;
					rstate_reg <= rtm_pkg::RTM_BUS_RDATA;
					rresp_reg <= RESP_OKAY;
					case ({s_axil_araddr[7:2], 2'b00})
					`RTM_STATUS_OFFSET:
						rdata_reg <= {24'h000000, status_view};
					`RTM_IRQ_STATUS_OFFSET:
						rdata_reg <= {30'h0, irq_status};
					`RTM_IRQ_ENABLE_OFFSET:
						rdata_reg <= {30'h0, irq_enable};
					`RTM_IRQ_CLEAR_OFFSET:
						rdata_reg <= 32'h0000_0000;
					default: begin
						rdata_reg <= 32'h0000_0000;
						rresp_reg <= RESP_SLVERR;
					end
					endcase
				end
			end
			rtm_pkg::RTM_BUS_RDATA: begin
				arready_reg <= 1'b0;
				if (s_axil_rready) begin
					rvalid_reg <= 1'b0;
					rstate_reg <= rtm_pkg::RTM_BUS_IDLE;
				end
			end
			default: begin
				rstate_reg <= rtm_pkg::RTM_BUS_IDLE;
				rvalid_reg <= 1'b0;
				arready_reg <= 1'b0;
			end
			endcase
		end
	end

	// Every output comes straight from a flip-flop.
	assign s_axil_awready = awready_reg;
	assign s_axil_wready = wready_reg;
	assign s_axil_bvalid = bvalid_reg;
	assign s_axil_bresp = bresp_reg;
	assign s_axil_arready = arready_reg;
	assign s_axil_rvalid = rvalid_reg;
	assign s_axil_rresp = rresp_reg;
	assign s_axil_rdata = rdata_reg;
	assign host_side_timeout_flag = host_flag_reg;
	assign card_side_timeout_flag = card_flag_reg;
	assign irq = irq_out;
endmodule

// File: rtm_retry_timeout_monitor_properties.sv
// Port-level checker for the retry timeout monitor.
// Assumes binding to rtm_retry_timeout_monitor, all on aclk.
`timescale 1ns/1ps
module rtm_retry_timeout_monitor_chk #(
	parameter int TIMEOUT_CYCLES = 32768
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic host_retry_issued,
	input wire logic card_retry_issued,
	input wire logic [31:0] s_axil_wdata,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic s_axil_awready,
	input wire logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic host_side_timeout_flag,
	input wire logic card_side_timeout_flag,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic clr_h, clr_c;
	assign clr_h = s_axil_wvalid && s_axil_wready && s_axil_wdata[1];
	assign clr_c = s_axil_wvalid && s_axil_wready && s_axil_wdata[3];
	a_host_expiry_time: assert property ($rose(host_side_timeout_flag) |->
		$past(host_retry_issued, TIMEOUT_CYCLES + 2)) else $error("host flag timing");
	a_card_expiry_time: assert property ($rose(card_side_timeout_flag) |->
		$past(card_retry_issued, TIMEOUT_CYCLES + 2)) else $error("card flag timing");
	a_host_flag_holds: assert property ($fell(host_side_timeout_flag) |->
		$past(clr_h, 2) || $past(clr_h, 3)) else $error("host flag lost");
	a_card_flag_holds: assert property ($fell(card_side_timeout_flag) |->
		$past(clr_c, 2) || $past(clr_c, 3)) else $error("card flag lost");
	a_bresp_stands: assert property (s_axil_bvalid && !s_axil_bready |=>
		s_axil_bvalid && $stable(s_axil_bresp)) else $error("bvalid dropped");
	a_rdata_stands: assert property (s_axil_rvalid && !s_axil_rready |=>
		s_axil_rvalid && $stable(s_axil_rdata)) else $error("rvalid dropped");
	a_upper_read_zero: assert property (s_axil_rvalid |->
		s_axil_rdata[31:8] == 24'h0) else $error("upper read bits set");
	a_ready_while_resp: assert property (s_axil_bvalid |->
		!s_axil_awready && !s_axil_wready) else $error("ready during response");
	a_irq_from_flag: assert property ($rose(irq) |->
		host_side_timeout_flag || card_side_timeout_flag) else $error("stray irq");
endmodule
bind rtm_retry_timeout_monitor rtm_retry_timeout_monitor_chk #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (.*);

// File: rtm_master_model.sv
// Retried bus masters of both sides, as one-clock strobes.
// Assumes pulse index 0 host retry, 1 host return, 2 card retry, 3 card return.
`timescale 1ns/1ps
module rtm_master_model (
	input wire logic aclk,
	output logic [3:0] strobes
);
	initial strobes = 4'h0;
	task automatic pulse(input int unsigned which);
		@(posedge aclk);
		strobes[which] <= 1'b1;
		@(posedge aclk);
		strobes[which] <= 1'b0;
	endtask
endmodule

// File: tb_retry_timeout_monitor.sv
// Self-checking bench for the retry timeout monitor over AXI4-Lite.
// Assumes the design, the master model and the checker compile first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	failures++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_retry_timeout_monitor;
	localparam int T = 16;
	logic aclk = 0;
	logic aresetn = 0;
	logic [3:0] strb;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, hflag, cflag, irq;
	logic [1:0] bresp, rresp, rs;
	int failures = 0;
	int comparisons = 0;
	always #2.5 aclk = ~aclk;
	rtm_master_model m_u (.aclk(aclk), .strobes(strb));
	rtm_retry_timeout_monitor #(.TIMEOUT_CYCLES(T)) dut_u (.aclk(aclk),
		.aresetn(aresetn), .host_retry_issued(strb[0]),
		.host_request_reissued(strb[1]), .card_retry_issued(strb[2]),
		.card_request_reissued(strb[3]), .s_axil_awaddr(awaddr),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
		.s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
		.s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .host_side_timeout_flag(hflag),
		.card_side_timeout_flag(cflag), .irq(irq));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ap, wp;
		ap = 1;
		wp = 1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		while (ap || wp) begin
			@(posedge aclk);
			if (ap && awready) begin
				ap = 0;
				awvalid <= 0;
			end
			if (wp && wready) begin
				wp = 0;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		rdr(a);
		`CHK("register", {24'h0, e}, rd)
	endtask
	task automatic wait_t;
		repeat (T + 4) @(posedge aclk);
	endtask
	task automatic summarize;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		chk_reg(8'h90, 8'hC0);
		$display("test reset done");
		m_u.pulse(0);
		m_u.pulse(2);
		wait_t();
		chk_reg(8'h90, 8'hCA);
		`CHK("flags", 2'b11, {cflag, hflag})
		wr(8'h90, 32'hFFFF_FFF5);
		`CHK("bresp", 2'b00, rs)
		chk_reg(8'h90, 8'hCA);
		wr(8'h90, 32'h0000_00C8);
		chk_reg(8'h90, 8'hC2);
		wr(8'h90, 32'h0000_00C2);
		chk_reg(8'h90, 8'hC0);
		$display("test expiry done");
		m_u.pulse(0);
		repeat (T / 2) @(posedge aclk);
		m_u.pulse(1);
		wait_t();
		chk_reg(8'h90, 8'hC0);
		m_u.pulse(2);
		repeat (T - 4) @(posedge aclk);
		m_u.pulse(2);
		repeat (T - 8) @(posedge aclk);
		chk_reg(8'h90, 8'hC0);
		repeat (12) @(posedge aclk);
		chk_reg(8'h90, 8'hC8);
		$display("test reissue done");
		wr(8'h90, 32'h0000_0008);
		chk_reg(8'h90, 8'h00);
		m_u.pulse(0);
		m_u.pulse(2);
		wait_t();
		chk_reg(8'h90, 8'h00);
		wr(8'h90, 32'h0000_0080);
		m_u.pulse(0);
		m_u.pulse(2);
		wait_t();
		chk_reg(8'h90, 8'h82);
		wr(8'h90, 32'h0000_00C2);
		$display("test enable done");
		wr(8'hA8, 32'h0000_0003);
		wr(8'hA4, 32'h0000_0001);
		m_u.pulse(2);
		wait_t();
		`CHK("irq", 1'b0, irq)
		chk_reg(8'hA0, 8'h02);
		m_u.pulse(0);
		wait_t();
		`CHK("irq", 1'b1, irq)
		wr(8'hA8, 32'h0000_0001);
		repeat (3) @(posedge aclk);
		`CHK("irq", 1'b0, irq)
		wr(8'h90, 32'h0000_00CA);
		chk_reg(8'h90, 8'hC0);
		$display("test irq done");
		m_u.pulse(0);
		wait_t();
		`CHK("irq", 1'b1, irq)
		wstrb <= 4'h0;
		wr(8'h90, 32'h0000_0002);
		`CHK("bresp", 2'b00, rs)
		chk_reg(8'h90, 8'hC2);
		wstrb <= 4'hF;
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		`CHK("flags", 2'b00, {cflag, hflag})
		`CHK("irq", 1'b0, irq)
		chk_reg(8'h90, 8'hC0);
		chk_reg(8'hA4, 8'h00);
		$display("test reset again done");
		rdr(8'h50);
		`CHK("rresp", 2'b10, rs)
		`CHK("rdata", 32'h0, rd)
		wr(8'h50, 32'h0000_0000);
		`CHK("bresp", 2'b10, rs)
		$display("test unmapped done");
		summarize();
	end
endmodule
